// [led_fault_pkg.sv]
/*
 * Shared constants and carrier types for the LED fault detect and
 * ghost removal block. Assumes a 48-channel driver (16 red, 16 green,
 * 16 blue) scanning up to 64 lines, reached over a simple strobe bus.
 */
package led_fault_pkg;

    // Channel organisation
    localparam int CHANNELS   = 48;
    localparam int GROUP      = 16;
    localparam int LINE_W     = 6;
    localparam int THR_W      = 4;
    localparam int GHOST_MAX  = 3;

    // Register bus widths
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_THRESH     = 8'h04;
    localparam logic [7:0] OFS_OPEN_LO    = 8'h08;
    localparam logic [7:0] OFS_OPEN_HI    = 8'h0C;
    localparam logic [7:0] OFS_SHORT_LO   = 8'h10;
    localparam logic [7:0] OFS_SHORT_HI   = 8'h14;
    localparam logic [7:0] OFS_LINE_IDX   = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1C;

    // Control field positions
    localparam int CTRL_RB_BIT      = 0;
    localparam int CTRL_GHOST_BIT   = 1;
    localparam int CTRL_CLAMP_LSB   = 4;

    // Line index register field positions
    localparam int LIDX_OPEN_LSB    = 0;
    localparam int LIDX_SHORT_LSB   = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [23:0] THRESH_RST = 24'h888_888;

    // Per-colour comparator thresholds, as laid out in the register
    typedef struct packed {
        logic [THR_W-1:0] short_thresh_blue;
        logic [THR_W-1:0] short_thresh_green;
        logic [THR_W-1:0] short_thresh_red;
        logic [THR_W-1:0] open_thresh_blue;
        logic [THR_W-1:0] open_thresh_green;
        logic [THR_W-1:0] open_thresh_red;
    } thresh_t;

    // One stored open-fault line for ghost removal
    typedef struct packed {
        logic [LINE_W-1:0]   line;
        logic [CHANNELS-1:0] mask;
    } ghost_entry_t;

    // Control register contents
    typedef struct packed {
        logic [3:0] short_ghost_removal_setting;
        logic       open_ghost_removal_enable;
        logic       fault_readback_enable;
    } ctrl_t;

endpackage

// [led_fault_detect_removal.sv]
/*
 * Protection, open/short LED diagnostics and open-LED ghost removal
 * for a 48-channel matrix driver. Assumes analog comparators and the
 * scan sequencer sit outside: they present per-channel compare results,
 * the channel-on request, the current line and a segment-end pulse, all
 * synchronous to clock.
 */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps

module led_fault_detect_removal (
    // Clock, enable, reset
    input  wire  logic                                 clock,
    input  wire  logic                                 clk_en,
    input  wire  logic                                 nrst,
    // Register port
    input  wire  logic [led_fault_pkg::ADDR_W-1:0]     addr,
    input  wire  logic [led_fault_pkg::DATA_W-1:0]     wdata,
    input  wire  logic                                 wr,
    input  wire  logic                                 rd,
    output logic       [led_fault_pkg::DATA_W-1:0]     rdata,
    // Protection comparators
    input  wire  logic                                 temp_above_trip,
    input  wire  logic                                 temp_below_release,
    input  wire  logic                                 current_reference_pin_below_trip,
    input  wire  logic                                 current_reference_pin_above_release,
    // Scan sequencer and channel comparators
    input  wire  logic                                 seg_end,
    input  wire  logic [led_fault_pkg::LINE_W-1:0]     line_idx,
    input  wire  logic [led_fault_pkg::CHANNELS-1:0]   chan_on,
    input  wire  logic [led_fault_pkg::CHANNELS-1:0]   open_cmp,
    input  wire  logic [led_fault_pkg::CHANNELS-1:0]   short_cmp,
    // Analog controls and channel drive
    output led_fault_pkg::thresh_t                     thresholds,
    output logic       [3:0]                           clamp_setting,
    output logic       [led_fault_pkg::CHANNELS-1:0]   channel_output
);

    localparam int CH = led_fault_pkg::CHANNELS;
    localparam int LW = led_fault_pkg::LINE_W;

    // Mask of channels stored for a given line
    function automatic logic [CH-1:0] ghost_mask(
        input led_fault_pkg::ghost_entry_t [2:0] ent,
        input logic [1:0]                        cnt,
        input logic [LW-1:0]                     line);
        logic [CH-1:0] m;
        m = '0;
        for (int i = 0; i < led_fault_pkg::GHOST_MAX; i++) begin
            if (2'(i) < cnt && ent[i].line == line) begin
                m = m | ent[i].mask;
            end
        end
        return m;
    endfunction

    // Register state
    led_fault_pkg::ctrl_t   ctrl_q, ctrl_d;
    led_fault_pkg::thresh_t thr_q, thr_d;
    logic [CH-1:0]          open_acc_q, open_acc_d;
    logic [CH-1:0]          short_acc_q, short_acc_d;
    logic [CH-1:0]          open_map_q, open_map_d;
    logic [CH-1:0]          short_map_q, short_map_d;
    logic [LW-1:0]          open_line_q, open_line_d;
    logic [LW-1:0]          short_line_q, short_line_d;
    logic [15:0]            open_snap_q, open_snap_d;
    logic [15:0]            short_snap_q, short_snap_d;
    logic                   thermal_q, thermal_d;
    logic                   current_reference_pin_q, current_reference_pin_d;
    logic [1:0]             ghost_cnt_q, ghost_cnt_d;
    led_fault_pkg::ghost_entry_t [2:0] ghost_q, ghost_d;
    logic [31:0]            rdata_q, rdata_d;

    // Samples valid only while the channel is driven
    logic [CH-1:0] open_now;
    logic [CH-1:0] short_now;
    logic [CH-1:0] blank_mask;
    logic          all_off;

    // Qualified compare results and output gating
    always_comb begin
        open_now   = open_acc_q | (channel_output & open_cmp);
        short_now  = short_acc_q | (channel_output & short_cmp);
        blank_mask = ctrl_q.open_ghost_removal_enable ?
                     ghost_mask(ghost_q, ghost_cnt_q, line_idx) : '0;
        all_off    = thermal_q | current_reference_pin_q;
    end

    assign channel_output = all_off ? '0 : (chan_on & ~blank_mask);
    assign thresholds     = thr_q;
    assign clamp_setting  = ctrl_q.short_ghost_removal_setting;
    assign rdata          = rdata_q;

    // Protection hysteresis: trip wins over release
    always_comb begin
        thermal_d = thermal_q;
        current_reference_pin_d    = current_reference_pin_q;
        if (temp_above_trip) begin
            thermal_d = 1'b1;
        end else if (temp_below_release) begin
            thermal_d = 1'b0;
        end
        if (current_reference_pin_below_trip) begin
            current_reference_pin_d = 1'b1;
        end else if (current_reference_pin_above_release) begin
            current_reference_pin_d = 1'b0;
        end
    end

    // Fault accumulation, segment latching and ghost table
    always_comb begin
        open_acc_d   = open_now;
        short_acc_d  = short_now;
        open_map_d   = open_map_q;
        short_map_d  = short_map_q;
        open_line_d  = open_line_q;
        short_line_d = short_line_q;
        ghost_cnt_d  = ghost_cnt_q;
        ghost_d      = ghost_q;
        if (seg_end) begin
            open_acc_d  = '0;
            short_acc_d = '0;
            open_map_d  = open_now;
            short_map_d = short_now;
            if (|open_now) begin
                open_line_d = line_idx;
            end
            if (|short_now) begin
                short_line_d = line_idx;
            end
            if (ctrl_q.open_ghost_removal_enable && |open_now) begin
                if (|ghost_mask(ghost_q, ghost_cnt_q, line_idx) ||
                    ghost_cnt_q == 2'(led_fault_pkg::GHOST_MAX)) begin
                    for (int i = 0; i < led_fault_pkg::GHOST_MAX; i++) begin
                        if (2'(i) < ghost_cnt_q &&
                            ghost_q[i].line == line_idx) begin
                            ghost_d[i].mask = ghost_q[i].mask | open_now;
                        end
                    end
                end else begin
                    ghost_d[ghost_cnt_q].line = line_idx;
                    ghost_d[ghost_cnt_q].mask = open_now;
                    ghost_cnt_d = ghost_cnt_q + 2'd1;
                end
            end
        end
        if (!ctrl_q.open_ghost_removal_enable) begin
            ghost_cnt_d = 2'd0;
        end
    end

    // Register port: writes, reads and high-half snapshots
    always_comb begin
        ctrl_d       = ctrl_q;
        thr_d        = thr_q;
        open_snap_d  = open_snap_q;
        short_snap_d = short_snap_q;
        rdata_d      = '0;
        if (wr && addr == led_fault_pkg::OFS_CTRL) begin
            ctrl_d = {wdata[led_fault_pkg::CTRL_CLAMP_LSB +: 4],
                      wdata[led_fault_pkg::CTRL_GHOST_BIT],
                      wdata[led_fault_pkg::CTRL_RB_BIT]};
        end
        if (wr && addr == led_fault_pkg::OFS_THRESH) begin
            thr_d = wdata[23:0];
        end
        if (rd) begin
            unique case (addr)
                led_fault_pkg::OFS_CTRL:
                    rdata_d = {24'h000000, ctrl_q.short_ghost_removal_setting,
                               2'b00, ctrl_q.open_ghost_removal_enable,
                               ctrl_q.fault_readback_enable};
                led_fault_pkg::OFS_THRESH:
                    rdata_d = {8'h00, thr_q};
                led_fault_pkg::OFS_OPEN_LO: begin
                    if (ctrl_q.fault_readback_enable) begin
                        rdata_d     = open_map_q[31:0];
                        open_snap_d = open_map_q[47:32];
                    end
                end
                led_fault_pkg::OFS_OPEN_HI:
                    if (ctrl_q.fault_readback_enable) begin
                        rdata_d = {16'h0000, open_snap_q};
                    end
                led_fault_pkg::OFS_SHORT_LO: begin
                    if (ctrl_q.fault_readback_enable) begin
                        rdata_d      = short_map_q[31:0];
                        short_snap_d = short_map_q[47:32];
                    end
                end
                led_fault_pkg::OFS_SHORT_HI:
                    if (ctrl_q.fault_readback_enable) begin
                        rdata_d = {16'h0000, short_snap_q};
                    end
                led_fault_pkg::OFS_LINE_IDX:
                    rdata_d = {18'h00000, short_line_q, 2'b00, open_line_q};
                led_fault_pkg::OFS_STATUS:
                    rdata_d = {28'h0000000, ghost_cnt_q, current_reference_pin_q, thermal_q};
                default:
                    rdata_d = '0;
            endcase
        end
    end

    // State registers, synchronous reset on nrst low; otherwise frozen while clk_en is low
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_q       <= led_fault_pkg::CTRL_RST[5:0];
            thr_q        <= led_fault_pkg::THRESH_RST;
            open_acc_q   <= '0;
            short_acc_q  <= '0;
            open_map_q   <= '0;
            short_map_q  <= '0;
            open_line_q  <= '0;
            short_line_q <= '0;
            open_snap_q  <= '0;
            short_snap_q <= '0;
            thermal_q    <= 1'b0;
            current_reference_pin_q       <= 1'b0;
            ghost_cnt_q  <= '0;
            ghost_q      <= '0;
            rdata_q      <= '0;
        end else if (clk_en) begin
            ctrl_q       <= ctrl_d;
            thr_q        <= thr_d;
            open_acc_q   <= open_acc_d;
            short_acc_q  <= short_acc_d;
            open_map_q   <= open_map_d;
            short_map_q  <= short_map_d;
            open_line_q  <= open_line_d;
            short_line_q <= short_line_d;
            open_snap_q  <= open_snap_d;
            short_snap_q <= short_snap_d;
            thermal_q    <= thermal_d;
            current_reference_pin_q       <= current_reference_pin_d;
            ghost_cnt_q  <= ghost_cnt_d;
            ghost_q      <= ghost_d;
            rdata_q      <= rdata_d;
        end
    end

    // Checks on protection, latching, ghost removal and readback
    AST_THERM_OFF: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && temp_above_trip |=> thermal_q && channel_output == '0)
        else $error("Outputs not off after thermal trip");
    AST_CURRENT_REFERENCE_PIN_OFF: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && current_reference_pin_below_trip |=> current_reference_pin_q && channel_output == '0)
        else $error("Outputs not off after reference trip");
    AST_CURRENT_REFERENCE_PIN_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        current_reference_pin_q && clk_en && !current_reference_pin_above_release && !current_reference_pin_below_trip
        |=> current_reference_pin_q)
        else $error("Reference shutdown released early");
    AST_OPEN_LATCH: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && seg_end |=> open_map_q ==
            $past(open_acc_q | (channel_output & open_cmp)))
        else $error("Open map does not match segment compare");
    AST_OPEN_OFFCH: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && seg_end && open_acc_q == '0 && channel_output == '0
        |=> open_map_q == '0)
        else $error("Open compare used while channel off");
    AST_SHORT_LATCH: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && seg_end |=> short_map_q ==
            $past(short_acc_q | (channel_output & short_cmp)))
        else $error("Short map does not match segment compare");
    AST_OPEN_LINE: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && seg_end && |open_now |=> open_line_q == $past(line_idx))
        else $error("Open line index not recorded");
    AST_MAP_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        !(clk_en && seg_end) |=> $stable(open_map_q) && $stable(short_map_q))
        else $error("Fault map changed outside segment end");
    AST_GHOST_BLANK: assert property (@(posedge clock) disable iff (!nrst)
        ctrl_q.open_ghost_removal_enable |->
            (channel_output & ghost_mask(ghost_q, ghost_cnt_q, line_idx)) == '0)
        else $error("Stored open channel driven on its line");
    AST_GHOST_CNT: assert property (@(posedge clock) disable iff (!nrst)
        ghost_cnt_q == 2'd3 |=> ghost_cnt_q == 2'd3 ||
            !$past(ctrl_q.open_ghost_removal_enable))
        else $error("Ghost table overflow or lost entry");
    AST_READ_CTRL: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && rd && addr == led_fault_pkg::OFS_CTRL
        |=> rdata[7:0] == {$past(ctrl_q.short_ghost_removal_setting),
            2'b00, $past(ctrl_q.open_ghost_removal_enable),
            $past(ctrl_q.fault_readback_enable)})
        else $error("Control readback wrong");
    COV_THERMAL: cover property (@(posedge clock) disable iff (!nrst)
        thermal_q ##1 !thermal_q);
    COV_GHOST_FULL: cover property (@(posedge clock) disable iff (!nrst)
        ghost_cnt_q == 2'd3);
    COV_SHORT_SEEN: cover property (@(posedge clock) disable iff (!nrst)
        clk_en && seg_end && |short_now);

endmodule

// [led_matrix_model.sv]
/* LED matrix model: each channel pin shows a voltage set by the bench,
   judged by the comparators against the per-colour thresholds.
   Assumes the bench owns the voltages; a pin that is off reads junk. */
`timescale 1ns/100ps
module led_matrix_model (
    // Clock
    input  wire logic                   clock,
    // Pin drive and thresholds
    input  wire logic [47:0]            channel_output,
    input  wire led_fault_pkg::thresh_t thresholds,
    // Four-bit pin voltage per channel
    input  wire logic [191:0]           volts,
    // Comparator results
    output logic      [47:0]            open_cmp,
    output logic      [47:0]            short_cmp
);
    logic [47:0] junk_q = 48'h1357_9BDF_2468;

    // Changing pattern seen on pins that are not driven
    always_ff @(posedge clock) begin
        junk_q <= ~{junk_q[46:0], junk_q[47] ^ junk_q[20]};
    end

    always_comb begin
        logic [3:0] v;
        logic [3:0] ot;
        logic [3:0] st;
        v  = '0;
        ot = '0;
        st = '0;
        for (int n = 0; n < 48; n++) begin
            v  = volts[n*4 +: 4];
            ot = thresholds[(n/16)*4 +: 4];
            st = thresholds[12 + (n/16)*4 +: 4];
            open_cmp[n]  = channel_output[n] ? (v > ot) : junk_q[n];
            short_cmp[n] = channel_output[n] ? (v < st) : ~junk_q[n];
        end
    end
endmodule

// [tb_top.sv]
/* Self-checking bench for the LED fault block: register port, random
   segments against a reference, protection, ghost removal.
   Assumes the LED matrix model answers the channel comparators. */
`timescale 1ns/100ps
module tb_top;
    logic                   clock = 1'b0;
    logic                   nrst = 1'b0;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic                   seg_end = 1'b0;
    logic                   t_hi = 1'b0;
    logic                   t_lo = 1'b0;
    logic                   i_lo = 1'b0;
    logic                   i_hi = 1'b0;
    logic [7:0]             addr = 8'h00;
    logic [31:0]            wdata = 32'h0;
    logic [31:0]            rdata;
    logic [31:0]            got;
    logic [5:0]             line_idx = 6'h00;
    logic [5:0]             lo = 6'h00;
    logic [5:0]             ls = 6'h00;
    logic [47:0]            chan_on = 48'h0;
    logic [47:0]            open_cmp;
    logic [47:0]            short_cmp;
    logic [47:0]            channel_output;
    logic [47:0]            exp_o = 48'h0;
    logic [47:0]            exp_s = 48'h0;
    logic [191:0]           volts = 192'h0;
    logic [23:0]            thr = 24'h888888;
    logic [3:0]             clamp_setting;
    led_fault_pkg::thresh_t thresholds;
    int                     errors = 0;
    int                     checks = 0;
    int                     gq[$] = '{5, 9, 12, 20};

    // Clock of 10 ns period
    always #5 clock = ~clock;

    led_fault_detect_removal u_dut (.clock(clock), .clk_en(1'b1),
        .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .temp_above_trip(t_hi), .temp_below_release(t_lo),
        .current_reference_pin_below_trip(i_lo), .current_reference_pin_above_release(i_hi),
        .seg_end(seg_end), .line_idx(line_idx), .chan_on(chan_on),
        .open_cmp(open_cmp), .short_cmp(short_cmp),
        .thresholds(thresholds), .clamp_setting(clamp_setting),
        .channel_output(channel_output));

    led_matrix_model u_matrix (.clock(clock),
        .channel_output(channel_output), .thresholds(thresholds),
        .volts(volts), .open_cmp(open_cmp), .short_cmp(short_cmp));

    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] expct);
        checks++;
        if (seen !== expct) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, expct, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    // One segment; reference ORs the valid flags of every cycle
    task automatic segment(input int n, input logic [5:0] ln, input bit rnd,
                           input logic [47:0] fon, input logic [191:0] fv);
        logic [47:0]  o;
        logic [191:0] vv;
        logic [47:0]  ao;
        logic [47:0]  as;
        ao = '0;
        as = '0;
        for (int i = 0; i < n; i++) begin
            o  = rnd ? 48'({$urandom(), $urandom()}) : fon;
            vv = fv;
            for (int k = 0; k < 6 && rnd; k++) vv[k*32 +: 32] = $urandom();
            for (int c = 0; c < 48; c++) begin
                ao[c] |= o[c] && (vv[c*4 +: 4] > thr[(c/16)*4 +: 4]);
                as[c] |= o[c] && (vv[c*4 +: 4] < thr[12 + (c/16)*4 +: 4]);
            end
            @(posedge clock);
            chan_on  <= o;
            volts    <= vv;
            line_idx <= ln;
            seg_end  <= (i == n - 1);
        end
        @(posedge clock);
        chan_on <= '0;
        seg_end <= 1'b0;
        exp_o = ao;
        exp_s = as;
        if (|ao) lo = ln;
        if (|as) ls = ln;
    endtask

    // Both maps read LO then HI, then the line indices
    task automatic check_maps();
        logic [47:0] m;
        for (int k = 0; k < 2; k++) begin
            rd_reg(8'(8 + k * 8));
            m[31:0] = got;
            rd_reg(8'(12 + k * 8));
            m[47:32] = got[15:0];
            check("fault_map", m, k ? exp_s : exp_o);
        end
        rd_reg(8'h18);
        check("line_index", 48'(got), 48'({ls, 2'b00, lo}));
    endtask

    // Bound on the whole run
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(4494));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd_reg(8'h04);
        check("thresh_reg", 48'(got), 48'h888888);
        check("thresh_out", 48'(thresholds), 48'h888888);
        segment(1, 6'h05, 1'b0, 48'h8, {48{4'hF}});
        rd_reg(8'h08);
        check("gated_map", 48'(got), 48'h0);
        wr_reg(8'h00, 32'h1);
        check_maps();
        for (int t = 0; t < 8; t++) begin
            thr = 24'($urandom());
            wr_reg(8'h04, {8'h00, thr});
            segment(1 + $urandom_range(4), 6'($urandom()), 1'b1, '0, '0);
            check_maps();
        end
        wr_reg(8'h18, 32'hFFFF_FFFF);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_reg(8'h20);
        check("unmapped", 48'(got), 48'h0);
        check_maps();
        wr_reg(8'h00, 32'h000000A1);
        rd_reg(8'h00);
        check("ctrl", 48'(got), 48'hA1);
        check("clamp", 48'(clamp_setting), 48'hA);
        thr = 24'h888888;
        wr_reg(8'h04, {8'h00, thr});
        volts <= {48{4'h8}};
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            chan_on <= '1;
            t_hi    <= (p == 0);
            i_lo    <= (p == 1);
            repeat (2) @(posedge clock);
            t_hi <= 1'b0;
            i_lo <= 1'b0;
            rd_reg(8'h1C);
            check("shut_flag", 48'(got[1:0]), 48'(p + 1));
            check("shut_out", channel_output, 48'h0);
            t_lo <= (p == 0);
            i_hi <= (p == 1);
            repeat (2) @(posedge clock);
            #1 check("resume", channel_output, '1);
            t_lo <= 1'b0;
            i_hi <= 1'b0;
        end
        segment(1, 6'h00, 1'b0, '0, '0);
        check_maps();
        wr_reg(8'h00, 32'h3);
        for (int i = 0; i < 4; i++)
            segment(1, 6'(gq[i]), 1'b0, 48'h1 << (i * 13), {48{4'hF}});
        rd_reg(8'h1C);
        check("ghost_count", 48'(got[3:2]), 48'h3);
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            chan_on  <= '1;
            line_idx <= 6'(gq[i % 4]);
            if (i == 4) wr <= 1'b1;
            addr  <= 8'h00;
            wdata <= 32'h1;
            #1 check("ghost_out", channel_output,
                     i % 4 < 3 ? ~(48'h1 << ((i % 4) * 13)) : '1);
        end
        @(posedge clock);
        wr <= 1'b0;
        #1 check("ghost_off", channel_output, '1);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd_reg(8'h00);
        check("ctrl_reset", 48'(got), 48'h0);
        report_and_stop();
    end
endmodule
